// ### hw/prt_top.sv
// Purpose: pin function select, reset pin handling and test port for one controller
// Assumes: APB master on CLK; test clock is its own domain; pads resolved outside
// Notes: all APB answers take no wait states; pin inputs read on CLK pass two flip-flops, tms and tdi go straight to the test port
//
// How it works
// - leaving reset, every multiplexed pin takes its primary function
// - alternative function only when enable bit set and select chosen
// - port a bit0 picks its alternative by the peripheral select register
// - test data input is captured on rising test clock edges
// - test data output driven only in shift states, changes on falling edge
// - test mode select sampled on rising test clock steps the controller
// - test logic runs only on the external test clock
// - reset pin low keeps the device in reset
// - internal reset released synchronously after a fixed cycle count
// - reset pin in port d bit4 role no longer resets the device
// - port d bit4 general-purpose output is open drain, never drives high
// - every port pin has its own input or output direction bit
// - converter control bit picks channel0 input or high reference on a0
`default_nettype none

module prt_top
   import prt_pkg::*;
(
   // clock and power-on reset
   input wire logic CLK,
   input wire logic RESET_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // test clock
   input wire logic TCK,
   // port d pads
   input wire logic [4:0] PAD_D_IN,
   output logic [4:0] PAD_D_OUT,
   output logic [4:0] PAD_D_OE,
   output logic TDO_OUT,
   output logic TDO_OE,
   // port a bit0 pad and analog routing
   input wire logic PAD_A0_IN,
   output logic PAD_A0_OUT,
   output logic PAD_A0_OE,
   input wire logic CMPC_OUT,
   output logic A0_TO_CH0,
   output logic A0_TO_VREFH,
   output logic A0_TO_CMP_A_POS2,
   // system reset
   input wire logic WDOG_RESET_REQ,
   output logic SYS_RESET_N
);

   logic [4:0] d_dir_reg, d_dir_next, d_data_reg, d_data_next, d_per_reg, d_per_next;
   logic a_dir_reg, a_dir_next, a_data_reg, a_data_next, a_per_reg, a_per_next;
   logic sel_reg, sel_next, cvt_reg, cvt_next, sw_rst_reg, sw_rst_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic wr_en;
   logic [4:0] d_meta_reg, d_sync_reg;
   logic a_meta_reg, a_sync_reg;
   logic shift_meta_reg, shift_sync_reg;
   logic tap_in_shift;
   logic [RST_CNT_W-1:0] cnt_reg, cnt_next;
   logic sys_rst_n_reg, sys_rst_n_next, rst_req;
   logic [4:0] d_out_reg, d_out_next, d_oe_reg, d_oe_next;
   logic a0_out_reg, a0_out_next, a0_oe_reg, a0_oe_next;
   logic ch0_reg, ch0_next, vrefh_reg, vrefh_next, cmpp_reg, cmpp_next;

   function automatic logic mapped(input logic [7:0] addr);
      mapped = (addr <= OFS_RST) && (addr[1:0] == 2'h0);
   endfunction

   // ----------------------------------------------------------------
   // register file over apb
   // ----------------------------------------------------------------
   assign wr_en = PSEL && PENABLE && pready_reg && PWRITE && mapped(PADDR);

   always_comb begin
      d_dir_next = d_dir_reg;
      d_data_next = d_data_reg;
      d_per_next = d_per_reg;
      a_dir_next = a_dir_reg;
      a_data_next = a_data_reg;
      a_per_next = a_per_reg;
      sel_next = sel_reg;
      cvt_next = cvt_reg;
      sw_rst_next = 1'b0;
      pready_next = PSEL && !PENABLE;
      pslverr_next = PSEL && !PENABLE && !mapped(PADDR);
      prdata_next = prdata_reg;
      if (wr_en) begin
         unique case (PADDR)
            OFS_D_DIR: d_dir_next = PWDATA[4:0];
            OFS_D_DATA: d_data_next = PWDATA[4:0];
            OFS_D_PER: d_per_next = PWDATA[4:0];
            OFS_A_DIR: a_dir_next = PWDATA[0];
            OFS_A_DATA: a_data_next = PWDATA[0];
            OFS_A_PER: a_per_next = PWDATA[0];
            OFS_SEL: sel_next = PWDATA[0];
            OFS_CVT: cvt_next = PWDATA[0];
            OFS_RST: sw_rst_next = PWDATA[RSTC_SW_BIT];
            default: sw_rst_next = 1'b0;
         endcase
      end
      if (PSEL && !PENABLE) begin
         prdata_next = 32'h0000_0000;
         unique case (PADDR)
            OFS_D_DIR: prdata_next[4:0] = d_dir_reg;
            OFS_D_DATA: prdata_next[4:0] = d_data_reg;
            OFS_D_PER: prdata_next[4:0] = d_per_reg;
            OFS_D_IN: prdata_next[4:0] = d_sync_reg;
            OFS_A_DIR: prdata_next[0] = a_dir_reg;
            OFS_A_DATA: prdata_next[0] = a_data_reg;
            OFS_A_PER: prdata_next[0] = a_per_reg;
            OFS_A_IN: prdata_next[0] = a_sync_reg;
            OFS_SEL: prdata_next[0] = sel_reg;
            OFS_CVT: prdata_next[0] = cvt_reg;
            OFS_RST: begin
               prdata_next[RSTC_SHIFT_BIT] = shift_sync_reg;
               prdata_next[RSTC_SYS_BIT] = !sys_rst_n_reg;
            end
            default: prdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         d_dir_reg <= RST_D_DIR;
         d_data_reg <= RST_D_DATA;
         d_per_reg <= RST_D_PER;
         a_dir_reg <= RST_A_DIR;
         a_data_reg <= RST_A_DATA;
         a_per_reg <= RST_A_PER;
         sel_reg <= RST_SEL;
         cvt_reg <= RST_CVT;
         sw_rst_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         d_dir_reg <= d_dir_next;
         d_data_reg <= d_data_next;
         d_per_reg <= d_per_next;
         a_dir_reg <= a_dir_next;
         a_data_reg <= a_data_next;
         a_per_reg <= a_per_next;
         sel_reg <= sel_next;
         cvt_reg <= cvt_next;
         sw_rst_reg <= sw_rst_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         d_meta_reg <= 5'h1F;
         d_sync_reg <= 5'h1F;
         a_meta_reg <= 1'b0;
         a_sync_reg <= 1'b0;
         shift_meta_reg <= 1'b0;
         shift_sync_reg <= 1'b0;
      end else begin
         d_meta_reg <= PAD_D_IN;
         d_sync_reg <= d_meta_reg;
         a_meta_reg <= PAD_A0_IN;
         a_sync_reg <= a_meta_reg;
         shift_meta_reg <= tap_in_shift;
         shift_sync_reg <= shift_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // internal reset sequencer
   // ----------------------------------------------------------------
   always_comb begin
      rst_req = (d_per_reg[D_RST] && !d_sync_reg[D_RST]) || WDOG_RESET_REQ || sw_rst_reg;
      cnt_next = cnt_reg;
      if (rst_req) begin
         cnt_next = '0;
      end else if (cnt_reg != RST_HOLD_CYCLES) begin
         cnt_next = cnt_reg + 6'h01;
      end
      sys_rst_n_next = !rst_req && (cnt_reg == RST_HOLD_CYCLES);
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cnt_reg <= '0;
         sys_rst_n_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         sys_rst_n_reg <= sys_rst_n_next;
      end
   end

   // ----------------------------------------------------------------
   // pad output muxes
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < PORT_D_W; i++) begin
         d_out_next[i] = d_data_reg[i];
         d_oe_next[i] = !d_per_reg[i] && d_dir_reg[i];
      end
      d_out_next[D_RST] = 1'b0;
      d_oe_next[D_RST] = !d_per_reg[D_RST] && d_dir_reg[D_RST] && !d_data_reg[D_RST];
      a0_out_next = a_data_reg;
      a0_oe_next = a_dir_reg;
      ch0_next = 1'b0;
      vrefh_next = 1'b0;
      cmpp_next = 1'b0;
      if (a_per_reg && sel_reg == SEL_A0_CMPC) begin
         a0_out_next = CMPC_OUT;
         a0_oe_next = 1'b1;
      end else if (a_per_reg) begin
         a0_oe_next = 1'b0;
         ch0_next = !cvt_reg;
         vrefh_next = cvt_reg;
         cmpp_next = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         d_out_reg <= 5'h00;
         d_oe_reg <= 5'h00;
         a0_out_reg <= 1'b0;
         a0_oe_reg <= 1'b0;
         ch0_reg <= 1'b0;
         vrefh_reg <= 1'b0;
         cmpp_reg <= 1'b0;
      end else begin
         d_out_reg <= d_out_next;
         d_oe_reg <= d_oe_next;
         a0_out_reg <= a0_out_next;
         a0_oe_reg <= a0_oe_next;
         ch0_reg <= ch0_next;
         vrefh_reg <= vrefh_next;
         cmpp_reg <= cmpp_next;
      end
   end

   // ----------------------------------------------------------------
   // test port
   // ----------------------------------------------------------------
   prt_tap u_tap (
      .tck(TCK),
      .reset_n(RESET_N),
      .tap_en(d_per_reg[D_TDI] && d_per_reg[D_TCK] && d_per_reg[D_TMS]),
      .tdo_en(d_per_reg[D_TDO]),
      .tms(PAD_D_IN[D_TMS]),
      .tdi(PAD_D_IN[D_TDI]),
      .tdo(TDO_OUT),
      .tdo_oe(TDO_OE),
      .in_shift(tap_in_shift)
   );

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign PAD_D_OUT = d_out_reg;
   assign PAD_D_OE = d_oe_reg;
   assign PAD_A0_OUT = a0_out_reg;
   assign PAD_A0_OE = a0_oe_reg;
   assign A0_TO_CH0 = ch0_reg;
   assign A0_TO_VREFH = vrefh_reg;
   assign A0_TO_CMP_A_POS2 = cmpp_reg;
   assign SYS_RESET_N = sys_rst_n_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   reset_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      rst_req |=> !sys_rst_n_reg [*8])
      else $error("internal reset released too early");
   reset_pin_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (d_per_reg[D_RST] && !d_sync_reg[D_RST]) |=> !sys_rst_n_reg)
      else $error("reset pin low did not hold reset");
   reset_gpio_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (!d_per_reg[D_RST] && !WDOG_RESET_REQ && !sw_rst_reg && sys_rst_n_reg) |=> sys_rst_n_reg)
      else $error("reset pin in port role still reset device");
   open_drain_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      PAD_D_OE[D_RST] |-> !PAD_D_OUT[D_RST] && !$past(d_data_reg[D_RST]))
      else $error("port d bit4 drives high");
   per_no_drive_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      $past(d_per_reg) != 5'h00 |-> (PAD_D_OE & $past(d_per_reg)) == 5'h00)
      else $error("gpio driver active on peripheral pin");
   gpio_follow_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      !a_per_reg |=> PAD_A0_OE == $past(a_dir_reg) && PAD_A0_OUT == $past(a_data_reg))
      else $error("port a bit0 does not follow its registers");
   analog_sel_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (a_per_reg && sel_reg != SEL_A0_CMPC) |=> A0_TO_VREFH == $past(cvt_reg)
      && A0_TO_CH0 != $past(cvt_reg))
      else $error("converter routing does not match control bit");
   cmpc_sel_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (a_per_reg && sel_reg == SEL_A0_CMPC) |=> PAD_A0_OE && !A0_TO_CMP_A_POS2)
      else $error("comparator output not routed to port a bit0");
   apb_ready_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
      else $error("apb answer not one cycle after setup");

endmodule // prt_top

`default_nettype wire

// ### pkg/prt_pkg.sv
// Purpose: shared constants and types for the pin function, reset and test port block
// Assumes: 32-bit APB data, word-aligned registers
// Notes: register offsets are byte addresses
`default_nettype none

package prt_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_D_DIR = 8'h00;
   localparam logic [7:0] OFS_D_DATA = 8'h04;
   localparam logic [7:0] OFS_D_PER = 8'h08;
   localparam logic [7:0] OFS_D_IN = 8'h0C;
   localparam logic [7:0] OFS_A_DIR = 8'h10;
   localparam logic [7:0] OFS_A_DATA = 8'h14;
   localparam logic [7:0] OFS_A_PER = 8'h18;
   localparam logic [7:0] OFS_A_IN = 8'h1C;
   localparam logic [7:0] OFS_SEL = 8'h20;
   localparam logic [7:0] OFS_CVT = 8'h24;
   localparam logic [7:0] OFS_RST = 8'h28;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int PORT_D_W = 5;
   localparam int D_TDI = 0;
   localparam int D_TDO = 1;
   localparam int D_TCK = 2;
   localparam int D_TMS = 3;
   localparam int D_RST = 4;
   localparam logic [4:0] RST_D_PER = 5'h1F;
   localparam logic [4:0] RST_D_DIR = 5'h00;
   localparam logic [4:0] RST_D_DATA = 5'h00;
   localparam logic RST_A_PER = 1'h0;
   localparam logic RST_A_DIR = 1'h0;
   localparam logic RST_A_DATA = 1'h0;
   localparam logic RST_SEL = 1'h0;
   localparam logic RST_CVT = 1'h0;
   localparam logic SEL_A0_CMPC = 1'h1;
   localparam int RSTC_SW_BIT = 0;
   localparam int RSTC_SHIFT_BIT = 1;
   localparam int RSTC_SYS_BIT = 2;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int RST_CNT_W = 6;
   localparam logic [5:0] RST_HOLD_CYCLES = 6'h20;

   // ----------------------------------------------------------------
   // test port
   // ----------------------------------------------------------------
   localparam int IR_W = 4;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam logic [3:0] IR_IDCODE = 4'h2;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   // arbitrary identification value
   localparam logic [31:0] TAP_ID_VALUE = 32'h1234_5001;

   typedef enum logic [15:0] {
      TAP_TLR = 16'h0001,
      TAP_IDLE = 16'h0002,
      TAP_SEL_DR = 16'h0004,
      TAP_CAP_DR = 16'h0008,
      TAP_SHIFT_DR = 16'h0010,
      TAP_EXIT1_DR = 16'h0020,
      TAP_PAUSE_DR = 16'h0040,
      TAP_EXIT2_DR = 16'h0080,
      TAP_UPD_DR = 16'h0100,
      TAP_SEL_IR = 16'h0200,
      TAP_CAP_IR = 16'h0400,
      TAP_SHIFT_IR = 16'h0800,
      TAP_EXIT1_IR = 16'h1000,
      TAP_PAUSE_IR = 16'h2000,
      TAP_EXIT2_IR = 16'h4000,
      TAP_UPD_IR = 16'h8000
   } prt_tap_state_t;

endpackage

`default_nettype wire

// ### hw/prt_tap.sv
// Purpose: test access port controller on the test clock
// Assumes: enables arrive as levels from the system clock domain
// Notes: forced to test-logic-reset while the test pins are not selected
`default_nettype none

module prt_tap
   import prt_pkg::*;
(
   // test clock domain
   input wire logic tck,
   input wire logic reset_n,
   // levels from system domain
   input wire logic tap_en,
   input wire logic tdo_en,
   // serial pins
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // status
   output logic in_shift
);

   prt_tap_state_t state_reg, state_next;
   logic [1:0] en_meta_reg, en_sync_reg;
   logic [IR_W-1:0] ir_sh_reg, ir_sh_next, ir_reg, ir_next;
   logic [31:0] dr_reg, dr_next;
   logic tdo_reg, tdo_next, oe_reg, oe_next;

   // ----------------------------------------------------------------
   // state and shift registers, rising edge
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      ir_sh_next = ir_sh_reg;
      ir_next = ir_reg;
      dr_next = dr_reg;
      unique case (state_reg)
         TAP_TLR: state_next = tms ? TAP_TLR : TAP_IDLE;
         TAP_IDLE: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: state_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: state_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: state_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: state_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: state_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: state_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
         TAP_UPD_DR: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: state_next = tms ? TAP_TLR : TAP_CAP_IR;
         TAP_CAP_IR: state_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: state_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: state_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: state_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: state_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
         TAP_UPD_IR: state_next = tms ? TAP_SEL_DR : TAP_IDLE;
         default: state_next = TAP_TLR;
      endcase
      unique case (state_reg)
         TAP_TLR: ir_next = IR_IDCODE;
         TAP_CAP_IR: ir_sh_next = IR_CAPTURE;
         TAP_SHIFT_IR: ir_sh_next = {tdi, ir_sh_reg[IR_W-1:1]};
         TAP_UPD_IR: ir_next = ir_sh_reg;
         TAP_CAP_DR: dr_next = (ir_reg == IR_IDCODE) ? TAP_ID_VALUE : 32'h0000_0000;
         TAP_SHIFT_DR: dr_next = (ir_reg == IR_IDCODE) ? {tdi, dr_reg[31:1]}
                                                        : {31'h0000_0000, tdi};
         default: dr_next = dr_reg;
      endcase
      if (!en_sync_reg[0]) begin
         state_next = TAP_TLR;
      end
   end

   always_ff @(posedge tck or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= TAP_TLR;
         en_meta_reg <= 2'h0;
         en_sync_reg <= 2'h0;
         ir_sh_reg <= 4'h0;
         ir_reg <= IR_IDCODE;
         dr_reg <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         en_meta_reg <= {tdo_en, tap_en};
         en_sync_reg <= en_meta_reg;
         ir_sh_reg <= ir_sh_next;
         ir_reg <= ir_next;
         dr_reg <= dr_next;
      end
   end

   // ----------------------------------------------------------------
   // serial output, falling edge
   // ----------------------------------------------------------------
   always_comb begin
      oe_next = en_sync_reg[1] && (state_reg == TAP_SHIFT_IR || state_reg == TAP_SHIFT_DR);
      tdo_next = (state_reg == TAP_SHIFT_IR) ? ir_sh_reg[0] : dr_reg[0];
      if (!oe_next) begin
         tdo_next = tdo_reg;
      end
   end

   always_ff @(negedge tck or negedge reset_n) begin
      if (!reset_n) begin
         tdo_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         tdo_reg <= tdo_next;
         oe_reg <= oe_next;
      end
   end

   assign tdo = tdo_reg;
   assign tdo_oe = oe_reg;
   assign in_shift = oe_reg;

   tms_reset_a: assert property (@(posedge tck) disable iff (!reset_n)
      tms [*5] |=> state_reg == TAP_TLR)
      else $error("five tms highs did not reach test-logic-reset");
   tap_off_a: assert property (@(posedge tck) disable iff (!reset_n)
      !en_sync_reg[0] |=> state_reg == TAP_TLR)
      else $error("deselected test port left reset state");
   tdo_shift_a: assert property (@(negedge tck) disable iff (!reset_n)
      oe_reg |-> $past(state_reg == TAP_SHIFT_IR || state_reg == TAP_SHIFT_DR))
      else $error("test data output driven outside shift states");

endmodule // prt_tap

`default_nettype wire

// ### tb/prt_probe.sv
// Purpose: debug probe and board reset source
// Assumes: test clock runs only inside a scan
// Notes: tms and tdi start high as pull-ups would; each scan leaves tms low; tck idles low
`default_nettype none

module prt_probe (
   // test pins
   output var logic tck,
   output var logic tms,
   output var logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe,
   // reset pin pull-down
   output var logic rst_low
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      tck = 0;
      tms = 1;
      tdi = 1;
      rst_low = 0;
   end

   task automatic hold(input logic v);
      rst_low = v;
   endtask

   // one test clock period, pins change while clock low
   task automatic tk(input logic m, input logic d, output logic o, output logic e);
      tms = m;
      tdi = d;
      #24 o = tdo;
      e = tdo_oe;
      tck = 1;
      #24 tck = 0;
   endtask

   task automatic scan(input logic tlr, input logic ir, input int n,
         input logic [31:0] din, output logic [31:0] dout, output logic [31:0] oe);
      logic o;
      logic e;
      dout = 0;
      oe = 0;
      if (tlr) begin
         repeat (5) tk(1, 1, o, e);
         tk(0, 1, o, e);
      end
      tk(1, 1, o, e);
      if (ir) tk(1, 1, o, e);
      tk(0, 1, o, e);
      tk(0, 1, o, e);
      for (int i = 0; i < n; i++) begin
         tk(i == n - 1, din[i], o, e);
         dout[i] = o;
         oe[i] = e;
      end
      tk(1, 1, o, e);
      tk(0, 1, o, e);
   endtask
endmodule // prt_probe

`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench for the pin function block
// Assumes: apb answers come when pready is seen
// Notes: pads resolved here with pull-ups
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import prt_pkg::*;

   logic clk = 0;
   logic rst_n = 1;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic cmpc = 0;
   logic wdog = 0;
   logic [31:0] prdata, rd, dout, oe;
   logic pready, pslverr, er, tdo_out, tdo_oe, a0_oe, a0_out, ch0, vrefh, cmpa, sys_rst_n;
   logic [4:0] d_out, d_oe;
   wire logic tck, tms, tdi, rst_low, d0, d1, d4;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;

   assign d0 = d_oe[0] ? d_out[0] : tdi;
   assign d1 = tdo_oe ? tdo_out : d_oe[1] ? d_out[1] : 1'b1;
   assign d4 = !(rst_low | (d_oe[4] & !d_out[4]));

   prt_top prt_top_i (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .TCK(tck), .PAD_D_IN({d4, tms, tck, d1, d0}), .PAD_D_OUT(d_out),
      .PAD_D_OE(d_oe), .TDO_OUT(tdo_out), .TDO_OE(tdo_oe),
      .PAD_A0_IN(a0_oe ? a0_out : 1'b1), .PAD_A0_OUT(a0_out), .PAD_A0_OE(a0_oe),
      .CMPC_OUT(cmpc), .A0_TO_CH0(ch0), .A0_TO_VREFH(vrefh), .A0_TO_CMP_A_POS2(cmpa),
      .WDOG_RESET_REQ(wdog), .SYS_RESET_N(sys_rst_n));

   prt_probe prt_probe_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(d1), .tdo_oe(tdo_oe),
      .rst_low(rst_low));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic results;
      if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, g, x);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n == 16) chk(0, 1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 0);
      chk(rd, x);
      chk(er, xe);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (2) @(posedge clk);
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         results();
      end
   end

   initial begin
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (30) @(posedge clk);
      chk(sys_rst_n, 0);
      repeat (10) @(posedge clk);
      chk(sys_rst_n, 1);
      rdc(OFS_D_PER, RST_D_PER, 0);
      rdc(OFS_D_DIR, RST_D_DIR, 0);
      rdc(OFS_A_PER, RST_A_PER, 0);
      rdc(OFS_SEL, RST_SEL, 0);
      rdc(OFS_D_IN, 32'h1B, 0);
      rdc(OFS_A_IN, 32'h1, 0);
      rdc(8'h2C, 0, 1);
      chk({d_oe, a0_oe, cmpa}, 0);
      prt_probe_i.scan(1, 0, 32, 0, dout, oe);
      chk(dout, TAP_ID_VALUE);
      chk(oe, 32'hFFFF_FFFF);
      prt_probe_i.scan(0, 1, 4, 32'hF, dout, oe);
      chk(dout, 32'h1);
      prt_probe_i.scan(0, 0, 8, 32'hA5, dout, oe);
      chk(dout, 32'h4A);
      chk(tdo_oe, 0);
      prt_probe_i.hold(1);
      repeat (6) @(posedge clk);
      chk(sys_rst_n, 0);
      prt_probe_i.hold(0);
      repeat (40) @(posedge clk);
      chk(sys_rst_n, 1);
      wr(OFS_D_PER, 32'h0E);
      prt_probe_i.scan(1, 0, 32, 0, dout, oe);
      chk(oe, 32'h0000_0000);
      chk(dout, 32'hFFFF_FFFF);
      prt_probe_i.hold(1);
      repeat (6) @(posedge clk);
      chk(sys_rst_n, 1);
      prt_probe_i.hold(0);
      wdog <= 1'b1;
      repeat (3) @(posedge clk);
      chk(sys_rst_n, 0);
      wdog <= 1'b0;
      repeat (40) @(posedge clk);
      wr(OFS_RST, 32'h1);
      chk(sys_rst_n, 0);
      rdc(OFS_RST, 32'h0000_0004, 0);
      repeat (40) @(posedge clk);
      wr(OFS_D_DIR, 32'h11);
      wr(OFS_D_DATA, 32'h01);
      chk({d_oe, d_out}, 10'h221);
      chk(sys_rst_n, 1);
      wr(OFS_D_DATA, 32'h11);
      chk({d_oe, d_out}, 10'h021);
      wr(OFS_SEL, SEL_A0_CMPC);
      wr(OFS_A_DIR, 32'h1);
      wr(OFS_A_DATA, 32'h1);
      chk({a0_oe, a0_out, cmpa}, 3'b110);
      wr(OFS_SEL, 32'h0);
      wr(OFS_A_PER, 32'h1);
      chk({a0_oe, cmpa, ch0, vrefh}, 4'b0110);
      wr(OFS_CVT, 32'h1);
      chk({a0_oe, cmpa, ch0, vrefh}, 4'b0101);
      cmpc <= 1'b1;
      wr(OFS_SEL, SEL_A0_CMPC);
      chk({a0_oe, a0_out}, 2'b11);
      cmpc <= 1'b0;
      repeat (3) @(posedge clk);
      chk(a0_out, 0);
      results();
   end
endmodule // tb_top

`default_nettype wire
